// File: rtl/nvmem_defines.vh
`ifndef NVMEM_DEFINES_VH
`define NVMEM_DEFINES_VH
// Device type code in the slave address; value arbitrary
`define DEV_TYPE_CODE    4'h5
`define MEM_DEPTH        8192
`define MEM_AW           13
`define MEM_LAST_ADDR    13'h1fff
`define MEM_ZERO_ADDR    13'h0000
`define BIT_CNT_W        4
`define BIT_LAST         4'h7
`define BIT_ACK          4'h8
`define BIT_ZERO         4'h0
`define BYTE_ZERO        8'h00
`define ADDR_HI_ZERO     5'h00
`define BIT_MSB          3'h7
`endif

// File: rtl/sync_2ff.v
`timescale 1ns/10ps
// Two-stage synchroniser per bit; the first stage feeds only the second
module sync_2ff (
  input  wire       sys_clk_in,
  input  wire       rstn_in,
  input  wire [5:0] async_in,
  output wire [5:0] sync_out
);
  reg [5:0] meta_r;
  reg [5:0] sync_r;
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : g_bit
      // Resets high so idle open-drain lines do not fake a start
      always @(posedge sys_clk_in) begin
        if (!rstn_in) begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
        end else begin
          meta_r[i] <= async_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate
  assign sync_out = sync_r;
endmodule

// File: rtl/two_wire_nv_memory_slave.v
`timescale 1ns/10ps
`include "nvmem_defines.vh"
// Notes on behaviour
// R1: Answer only when select pins equal slave address bits 3..1; eight devices per bus.
// R2: Unconnected select pins read as zero (pulled low outside this logic).
// R3: Sample data on clock rise; change outgoing data on clock fall.
// R4: Data line is only pulled low or released, never driven high.
// R5: Write-protect high blocks all writes; low allows all writes.
// R6: Unconnected write-protect reads low, meaning unprotected.
// R7: 8192 locations of eight bits each.
// R8: Slave address byte first, then a two-byte memory address accepted.
// R9: Only the low 13 address bits select; upper three ignored.
// R10: Master should send zeros in the unused upper address bits.
// R11: Writes complete within the transfer; never busy.
// R12: Works at bus clock rates up to 1 MHz, including 100 and 400 kHz.
// R13: Address byte: type in bits 7..4, select in 3..1, bit 0 read high.
// R14: Address latch increments after each data byte, wrapping 1fff to 0.
// R15: Reads continue on master acknowledge; no acknowledge ends the read.
// R16: Byte committed only after eighth bit; start or stop before aborts it.
// R17: Acknowledge matched address and each received byte; start/stop resets interface.
module two_wire_nv_memory_slave (
  input  wire       sys_clk_in,
  input  wire       rstn_in,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire [2:0] device_select_pins_in,
  input  wire       write_protect_in,
  output reg        sda_out,
  output reg        sda_oe_out
);
  // Protocol phases
  localparam ST_IDLE  = 6'b000001;
  localparam ST_DEVAD = 6'b000010;
  localparam ST_ADRHI = 6'b000100;
  localparam ST_ADRLO = 6'b001000;
  localparam ST_WDATA = 6'b010000;
  localparam ST_RDATA = 6'b100000;

  wire [5:0] sync_w;
  wire       scl_s;
  wire       sda_s;
  wire [2:0] sel_s;
  wire       wp_s;

  // All pins cross into the system clock; at 250 MHz a 1 MHz bus is amply oversampled
  sync_2ff u_sync (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .async_in   ({write_protect_in, device_select_pins_in, sda_in, scl_in}),
    .sync_out   (sync_w)
  ); // see R12
  assign scl_s = sync_w[0];
  assign sda_s = sync_w[1];
  assign sel_s = sync_w[4:2]; // see R2
  assign wp_s  = sync_w[5];   // see R6

  reg [7:0]               mem_r [0:`MEM_DEPTH-1]; // see R7
  reg                     scl_d_r;
  reg                     sda_d_r;
  reg [5:0]               state_r;
  reg [`BIT_CNT_W-1:0]    bit_cnt_r;
  reg [7:0]               shift_r;
  reg [`MEM_AW-1:0]       addr_r;
  reg [4:0]               addr_hi_r;
  reg                     ack_phase_r;
  reg                     ack_drive_r;
  reg                     rd_ack_ok_r;
  reg [7:0]               tx_r;

  wire scl_rise = scl_s & ~scl_d_r;  // see R3
  wire scl_fall = ~scl_s & scl_d_r;  // see R3
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire [7:0] rx_byte = {shift_r[6:0], sda_s};
  wire [`MEM_AW-1:0] addr_inc = (addr_r == `MEM_LAST_ADDR) ? `MEM_ZERO_ADDR :
                                addr_r + 1'b1; // see R14

  // Edge detect history of the synchronised lines
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Memory commit on the eighth data bit; nothing earlier touches the array
  always @(posedge sys_clk_in) begin
    if (state_r == ST_WDATA && scl_rise && !ack_phase_r &&
        bit_cnt_r == `BIT_LAST && !wp_s) begin // see R5 see R16 see R11
      mem_r[addr_r] <= rx_byte;
    end
  end

  // Bit engine: sample on rise, update the pin on fall
  always @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state_r     <= ST_IDLE;
      bit_cnt_r   <= `BIT_ZERO;
      shift_r     <= `BYTE_ZERO;
      addr_r      <= `MEM_ZERO_ADDR;
      addr_hi_r   <= `ADDR_HI_ZERO;
      ack_phase_r <= 1'b0;
      ack_drive_r <= 1'b0;
      rd_ack_ok_r <= 1'b0;
      tx_r        <= `BYTE_ZERO;
      sda_out     <= 1'b0;
      sda_oe_out  <= 1'b0;
    end else if (start_c) begin
      // Start aborts anything in flight and expects a slave address
      state_r     <= ST_DEVAD; // see R17 see R16
      bit_cnt_r   <= `BIT_ZERO;
      ack_phase_r <= 1'b0;
      ack_drive_r <= 1'b0;
      sda_oe_out  <= 1'b0;
    end else if (stop_c) begin
      state_r     <= ST_IDLE; // see R17 see R16
      bit_cnt_r   <= `BIT_ZERO;
      ack_phase_r <= 1'b0;
      ack_drive_r <= 1'b0;
      sda_oe_out  <= 1'b0;
    end else if (scl_rise) begin
      if (ack_phase_r) begin
        ack_phase_r <= 1'b0;
        bit_cnt_r   <= `BIT_ZERO;
        if (state_r == ST_RDATA) begin
          // Master acknowledge keeps the read going; none ends it
          rd_ack_ok_r <= ~sda_s; // see R15
          if (sda_s) begin
            state_r <= ST_IDLE; // see R15
          end
        end
      end else if (state_r != ST_IDLE) begin
        shift_r   <= rx_byte;
        bit_cnt_r <= bit_cnt_r + 1'b1;
        if (bit_cnt_r == `BIT_LAST) begin
          ack_phase_r <= 1'b1;
          ack_drive_r <= 1'b0;
          case (state_r)
            ST_DEVAD: begin
              // Type code and select bits must both match
              if (rx_byte[7:4] == `DEV_TYPE_CODE &&
                  rx_byte[3:1] == sel_s) begin // see R1 see R13
                ack_drive_r <= 1'b1;           // see R17
                rd_ack_ok_r <= rx_byte[0];
                tx_r        <= mem_r[addr_r];
                state_r     <= rx_byte[0] ? ST_RDATA : ST_ADRHI; // see R13 see R8
              end else begin
                state_r <= ST_IDLE;
              end
            end
            ST_ADRHI: begin
              addr_hi_r   <= rx_byte[4:0]; // see R9
              ack_drive_r <= 1'b1;          // see R8
              state_r     <= ST_ADRLO;
            end
            ST_ADRLO: begin
              addr_r      <= {addr_hi_r, rx_byte}; // see R8 see R9
              ack_drive_r <= 1'b1;
              state_r     <= ST_WDATA;
            end
            ST_WDATA: begin
              // Protected bytes are still acknowledged, only not stored
              addr_r      <= addr_inc; // see R14
              ack_drive_r <= 1'b1;     // see R17
            end
            ST_RDATA: begin
              addr_r <= addr_inc; // see R14
            end
            default: begin
              state_r <= ST_IDLE;
            end
          endcase
        end
      end
    end else if (scl_fall) begin
      // Outside start and stop the pin changes only on the falling edge, and only ever low or released
      sda_out <= 1'b0; // see R4
      if (ack_phase_r) begin
        sda_oe_out <= ack_drive_r; // see R3 see R17
      end else if (state_r == ST_RDATA && rd_ack_ok_r) begin
        if (bit_cnt_r == `BIT_ZERO && ack_drive_r == 1'b0) begin
          tx_r <= mem_r[addr_r];
        end
        sda_oe_out <= ~((bit_cnt_r == `BIT_ZERO) ? mem_r[addr_r][7] :
                        tx_r[`BIT_MSB - bit_cnt_r[2:0]]); // see R4 see R3
        ack_drive_r <= 1'b0;
      end else begin
        sda_oe_out <= 1'b0;
      end
    end
  end
endmodule

// File: bench/nvmem_sva.sv
`timescale 1ns/10ps
// Pin timing of the open-drain data output
module nvmem_sva (
  input wire sys_clk_in,
  input wire rstn_in,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_out
);
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_low; sda_out == 1'b0; endproperty
  a_low: assert property (p_low) else $error("driven high");
  property p_up_lo; $rose(sda_oe_out) |-> !$past(scl_in, 2); endproperty
  a_up_lo: assert property (p_up_lo) else $error("pull early");
  property p_up_hi; $rose(sda_oe_out) |-> $past(scl_in, 6); endproperty
  a_up_hi: assert property (p_up_hi) else $error("pull late");
  property p_dn; $fell(sda_oe_out) |-> !$past(scl_in, 2); endproperty
  a_dn: assert property (p_dn) else $error("release off fall");
  property p_hi; scl_in && $past(scl_in, 2) && $past(scl_in, 5) |-> $stable(sda_oe_out); endproperty
  a_hi: assert property (p_hi) else $error("moved in high");
  property p_hold; $rose(sda_oe_out) |-> sda_oe_out [*8]; endproperty
  a_hold: assert property (p_hold) else $error("pull short");
  property p_rst; $rose(rstn_in) |-> !sda_oe_out; endproperty
  a_rst: assert property (p_rst) else $error("pull at reset");
  property p_stop; scl_in && $past(scl_in) && $rose(sda_in) |-> ##5 !sda_oe_out; endproperty
  a_stop: assert property (p_stop) else $error("pull after stop");
endmodule
bind two_wire_nv_memory_slave nvmem_sva u_sva (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out));

// File: bench/bus_master_model.sv
`timescale 1ns/10ps
// Bus master; its clock idles high between frames
module bus_master_model (
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_low_out
);
  reg   [8:0] res_r;
  event       res_ev;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Start is cond(0,1), stop is cond(1,0): data moves while clock high
  task cond(input a, input b);
    begin
      sda_low_out = a;
      #16 scl_out = 1'b1;
      #16 sda_low_out = b;
      #16 scl_out = !b;
      #16;
    end
  endtask
  // Data set in the low half, wire read at the end of the high half
  task bit_x(input b, output r);
    begin
      sda_low_out = !b;
      #16 scl_out = 1'b1;
      #32 r = sda_in;
      scl_out = 1'b0;
      #16;
    end
  endtask
  // Byte MSB first, then the acknowledge bit from ack_bit
  task xfer(input [7:0] d, input ack_bit);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_x(d[i], res_r[i+1]);
      bit_x(ack_bit, res_r[0]);
      -> res_ev;
    end
  endtask
endmodule

// File: bench/tb_top.sv
`timescale 1ns/10ps
`include "nvmem_defines.vh"
module tb_top;
  reg         sys_clk_in;
  reg         rstn_in;
  reg  [2:0]  sel_r;
  reg         wp_r;
  reg  [31:0] rnd_r;
  reg  [7:0]  d0, d1;
  reg         junk;
  integer     fails, samples_checked, cyc, i;
  reg  [8:0]  expq[$];
  wire        scl, sda_low, sda_o, sda_oe, sda_w;
  // Pull-up wins unless a party pulls low
  assign sda_w = !(sda_low | (sda_oe & !sda_o));
  two_wire_nv_memory_slave u_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .scl_in(scl),
    .sda_in(sda_w), .device_select_pins_in(sel_r), .write_protect_in(wp_r), .sda_out(sda_o),
    .sda_oe_out(sda_oe));
  bus_master_model u_mst (.sda_in(sda_w), .scl_out(scl), .sda_low_out(sda_low));
  task chk(input [8:0] seen, input [8:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("Checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // Note the expected wire byte and acknowledge, then move it
  task xb(input [7:0] d, input a, input [8:0] e);
    begin
      expq.push_back(e);
      u_mst.xfer(d, a);
    end
  endtask
  task adr(input [2:0] s, input rw, input ok);
    xb({`DEV_TYPE_CODE, s, rw}, 1'b1, {`DEV_TYPE_CODE, s, rw, !ok});
  endtask
  task seta(input [15:0] a);
    begin
      u_mst.cond(1'b0, 1'b1);
      adr(sel_r, 1'b0, 1'b1);
      xb(a[15:8], 1'b1, {a[15:8], 1'b0});
      xb(a[7:0], 1'b1, {a[7:0], 1'b0});
    end
  endtask
  // Random read of two bytes, master acknowledges the first only
  task rd2(input [15:0] a, input [7:0] e0, input [7:0] e1);
    begin
      seta(a);
      u_mst.cond(1'b0, 1'b1);
      adr(sel_r, 1'b1, 1'b1);
      xb(8'hff, 1'b0, {e0, 1'b0});
      xb(8'hff, 1'b1, {e1, 1'b1});
      u_mst.cond(1'b1, 1'b0);
    end
  endtask
  // Pseudo-random source for straps and data
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // Results are compared in issue order
  initial forever begin
    @(u_mst.res_ev);
    chk(u_mst.res_r, expq.pop_front());
  end
  // Hang guard, far above the expected 5300 cycles
  initial begin
    for (cyc = 0; cyc < 20000; cyc = cyc + 1) @(posedge sys_clk_in);
    fails = fails + 1;
    end_sim;
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    rnd_r = lfsr(32'h2ec5);
    {sel_r, wp_r, rstn_in} = {rnd_r[2:0], 2'b00};
    d0 = rnd_r[15:8];
    d1 = rnd_r[23:16] | 8'h01;
    repeat (5) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rstn_in = 1'b1;
    repeat (8) @(negedge sys_clk_in);
    seta(16'hffff);
    xb(d0, 1'b1, {d0, 1'b0});
    xb(d1, 1'b1, {d1, 1'b0});
    u_mst.cond(1'b1, 1'b0);
    rd2(16'h1fff, d0, d1);
    for (i = 1; i < 8; i = i + 1) begin
      u_mst.cond(1'b0, 1'b1);
      adr(sel_r ^ i[2:0], 1'b0, 1'b0);
      u_mst.cond(1'b1, 1'b0);
    end
    wp_r = 1'b1;
    seta(16'h1fff);
    xb(~d0, 1'b1, {~d0, 1'b0});
    u_mst.cond(1'b1, 1'b0);
    wp_r = 1'b0;
    rd2(16'h1fff, d0, d1);
    seta(16'h0000);
    // Six bits here; the stop's own clock pulse is the seventh, so no eighth bit lands
    repeat (6) u_mst.bit_x(1'b0, junk);
    u_mst.cond(1'b1, 1'b0);
    u_mst.cond(1'b0, 1'b1);
    adr(sel_r, 1'b1, 1'b1);
    xb(8'hff, 1'b1, {d1, 1'b1});
    u_mst.cond(1'b1, 1'b0);
    end_sim;
  end
endmodule
